// File: logic/rlc_card.sv
// Purpose: One driver card: two-stage shift path and two output latches.
// Assumes: Shift, load and clear arrive as one-cycle strobes and a level on mclk_in.
// Notes: Clear wins over load and shift; load samples stages before any shift.
`timescale 1ns/1ps
`include "rlc_params.svh"

module rlc_card (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	rlc_card_if.card link
);
	import rlc_pkg::*;

	rlc_card_state_t st;
	rlc_card_state_t next_st;

	// Next state: clear first, then load and shift from the present stages.
	always_comb begin
		next_st = st;
		if (!link.clear_n) begin
			next_st = '{default: `RLC_ZERO_BYTE};
		end else begin
			if (link.load) begin
				next_st.first_output_latch = st.first_shift_stage;
				next_st.second_output_latch = st.second_shift_stage;
			end
			if (link.shift) begin
				next_st.first_shift_stage = link.din;
				next_st.second_shift_stage = st.first_shift_stage;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st <= '{default: `RLC_ZERO_BYTE};
		end else begin
			st <= next_st;
		end
	end

	// Second stage feeds the next card; latches drive the twelve transistors.
	assign link.dout = st.second_shift_stage;
	assign link.drive = {st.second_output_latch, st.first_output_latch};

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);

	sequence s_shift_req;
		link.shift && link.clear_n;
	endsequence

	property p_shift_moves;
		s_shift_req |=> st.first_shift_stage == $past(link.din) &&
			st.second_shift_stage == $past(st.first_shift_stage);
	endproperty
	a_shift_moves: assert property (p_shift_moves) else $error("shift did not move stages");

	property p_load_copies;
		link.load && link.clear_n |=> link.drive ==
			{$past(st.second_shift_stage), $past(st.first_shift_stage)};
	endproperty
	a_load_copies: assert property (p_load_copies) else $error("load did not copy stages");

	property p_clear_zero;
		!link.clear_n |=> st == '0;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("clear left bits set");

	property p_hold;
		!link.shift && !link.load && link.clear_n |=> $stable(st);
	endproperty
	a_hold: assert property (p_hold) else $error("card state changed without a strobe");

	property p_drive_steady;
		!link.load && link.clear_n |=> $stable(link.drive);
	endproperty
	a_drive_steady: assert property (p_drive_steady) else $error("drivers moved without load");
endmodule

// File: logic/rlc_card_if.sv
// Purpose: Carrier between the chain front end and one driver card.
// Assumes: One instance per card, all on the chain clock.
// Notes: Shift, load and clear are common to all cards; data is per card.
`timescale 1ns/1ps
`include "rlc_params.svh"

interface rlc_card_if;
	import rlc_pkg::*;
	logic shift;
	logic load;
	logic clear_n;
	rlc_byte_t din;
	rlc_byte_t dout;
	logic [`RLC_DRV_W-1:0] drive;

	modport card (input shift, input load, input clear_n, input din, output dout, output drive);
	modport chain (output shift, output load, output clear_n, output din, input dout,
		input drive);
endinterface

// File: logic/rlc_chain.sv
// Purpose: Six driver cards chained behind the bus listener's shift, load and clear.
// Assumes: Listener pins are asynchronous to mclk_in and each pulse spans several clocks.
// Notes: Pin edges are synchronised and turned into one-cycle strobes.
//
// Behaviour
// - Each card holds two six-bit bytes in two stages, six cards giving twelve bytes.
// - A shift moves input into stage one, stage one into stage two, stage two onward.
// - Card one shifts from the listener data; each later card from the card before.
// - After twelve shifts the first byte sits in stage two of the sixth card.
// - A load copies stage one into latch one and stage two into latch two on all cards.
// - While clear is low every stage and latch bit on every card is zero.
// - A high latch bit turns its driver on and a low bit leaves it off.
// - Latch one drives outputs one to six and latch two outputs seven to twelve.
// - Shift, load and clear go in common to every card of the chain.
// - All seventy-two relay positions can always be driven, installed or not.
`timescale 1ns/1ps
`include "rlc_params.svh"

module rlc_chain (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire rlc_pkg::rlc_byte_t chain_data_in,
	input wire logic chain_shift_pulse_in,
	input wire logic chain_load_pulse_in,
	input wire logic chain_clear_n_in,
	output logic [`RLC_ALL_DRV_W-1:0] relay_drive_out,
	output rlc_pkg::rlc_byte_t chain_data_out
);
	import rlc_pkg::*;

	rlc_front_state_t st;
	rlc_front_state_t next_st;
	logic shift_evt;
	logic load_evt;

	// Two-flop synchronisers; the third shift and load flops only serve edge detection.
	always_comb begin
		next_st = st;
		next_st.data_s1 = chain_data_in;
		next_st.data_s2 = st.data_s1;
		next_st.shift_s1 = chain_shift_pulse_in;
		next_st.shift_s2 = st.shift_s1;
		next_st.shift_s3 = st.shift_s2;
		next_st.load_s1 = chain_load_pulse_in;
		next_st.load_s2 = st.load_s1;
		next_st.load_s3 = st.load_s2;
		next_st.clear_n_s1 = chain_clear_n_in;
		next_st.clear_n_s2 = st.clear_n_s1;
	end

	// Clear idles high so a reset release does not look like a clear request.
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st <= '{data_s1: `RLC_ZERO_BYTE, data_s2: `RLC_ZERO_BYTE,
				clear_n_s1: `RLC_ONE_BIT, clear_n_s2: `RLC_ONE_BIT,
				default: `RLC_ZERO_BIT};
		end else begin
			st <= next_st;
		end
	end

	// A long listener pulse yields exactly one strobe at its rising edge.
	assign shift_evt = st.shift_s2 && !st.shift_s3;
	assign load_evt = st.load_s2 && !st.load_s3;

	rlc_card_if card_if [`RLC_CARDS] ();

	// The cards sit in a daisy chain with common control strobes.
	genvar g;
	generate
		for (g = 0; g < `RLC_CARDS; g++) begin : gen_card
			assign card_if[g].shift = shift_evt;
			assign card_if[g].load = load_evt;
			assign card_if[g].clear_n = st.clear_n_s2;
			if (g == 0) begin : gen_head
				assign card_if[g].din = st.data_s2;
			end else begin : gen_link
				assign card_if[g].din = card_if[g-1].dout;
			end
			rlc_card u_card (
				.mclk_in(mclk_in),
				.arst_n_in(arst_n_in),
				.link(card_if[g])
			);
			// Every card drives its full twelve outputs whether relays are fitted or not.
			assign relay_drive_out[g*`RLC_DRV_W +: `RLC_DRV_W] = card_if[g].drive;
		end
	endgenerate

	// The tail of the chain is visible so a host can check what fell off the end.
	assign chain_data_out = card_if[`RLC_CARDS-1].dout;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);

	sequence s_shift_pin_rise;
		$rose(chain_shift_pulse_in);
	endsequence

	sequence s_load_pin_rise;
		$rose(chain_load_pulse_in);
	endsequence

	property p_shift_fanout;
		s_shift_pin_rise ##2 1'b1 |-> shift_evt;
	endproperty
	a_shift_fanout: assert property (p_shift_fanout) else $error("shift pin edge lost");

	property p_load_fanout;
		s_load_pin_rise ##2 1'b1 |-> load_evt;
	endproperty
	a_load_fanout: assert property (p_load_fanout) else $error("load pin edge lost");

	property p_one_strobe;
		shift_evt |=> !shift_evt;
	endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("shift strobe too long");

	property p_clear_outputs;
		!st.clear_n_s2 |=> relay_drive_out == `RLC_ZERO_DRV;
	endproperty
	a_clear_outputs: assert property (p_clear_outputs) else $error("drivers on during clear");

	// Checked at a nine-clock character pace; other strobe spacings are not covered here.
	property p_tail_moves;
		shift_evt && st.clear_n_s2 ##1 (!shift_evt && st.clear_n_s2) [*8] ##1 shift_evt &&
			st.clear_n_s2 |=> chain_data_out == $past(card_if[`RLC_CARDS-2].dout, 10);
	endproperty
	a_tail_moves: assert property (p_tail_moves) else $error("chain tail did not advance");
endmodule

// File: logic/rlc_params.svh
// Purpose: Named sizes and reset values for the relay latch shift chain.
// Assumes: Included by the package and by the design modules by bare name.
// Notes: Definitions only, no logic.
`ifndef RLC_PARAMS_SVH
`define RLC_PARAMS_SVH

// Number of driver cards in the daisy chain.
`define RLC_CARDS 6
// Width of one shifted byte, and of one output latch.
`define RLC_BYTE_W 6
// Driver outputs per card.
`define RLC_DRV_W 12
// Driver outputs of the whole chain.
`define RLC_ALL_DRV_W 72
// Bytes held by the whole chain.
`define RLC_CHAIN_BYTES 12
// Cleared value of one stage or latch.
`define RLC_ZERO_BYTE 6'h00
// Cleared value of a synchroniser bit.
`define RLC_ZERO_BIT 1'h0
// Idle level of the active-low clear synchroniser.
`define RLC_ONE_BIT 1'h1
// Cleared value of the whole driver bank.
`define RLC_ZERO_DRV 72'h0

`endif

// File: logic/rlc_pkg.sv
// Purpose: Types shared by the relay latch shift chain modules.
// Assumes: Sizes come from the parameter header.
// Notes: Each module keeps its whole state in one packed struct.
`include "rlc_params.svh"

package rlc_pkg;

	typedef logic [`RLC_BYTE_W-1:0] rlc_byte_t;

	// State of one driver card: two shift stages and two output latches.
	typedef struct packed {
		rlc_byte_t first_shift_stage;
		rlc_byte_t second_shift_stage;
		rlc_byte_t first_output_latch;
		rlc_byte_t second_output_latch;
	} rlc_card_state_t;

	// State of the chain front end: synchronisers for the listener pins.
	typedef struct packed {
		rlc_byte_t data_s1;
		rlc_byte_t data_s2;
		logic shift_s1;
		logic shift_s2;
		logic shift_s3;
		logic load_s1;
		logic load_s2;
		logic load_s3;
		logic clear_n_s1;
		logic clear_n_s2;
	} rlc_front_state_t;

endpackage

// File: testbench/relay_latch_shift_chain_test.sv
// Purpose: Self-checking bench for the relay latch shift chain.
// Assumes: The listener model paces all pins on the falling edge.
// Notes: Expected driver banks are rebuilt from byte order alone.
`timescale 1ns/1ps
`include "rlc_params.svh"

module relay_latch_shift_chain_test;
	import rlc_pkg::*;
	logic mclk_in;
	logic arst_n_in;
	rlc_byte_t data;
	logic shift;
	logic load;
	logic clear_n;
	logic [`RLC_ALL_DRV_W-1:0] drive;
	rlc_byte_t tail;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;

	// Shift, load and clear reach the chain on one shared set of wires.
	rlc_chain rlc_chain_i (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .chain_data_in(data),
		.chain_shift_pulse_in(shift), .chain_load_pulse_in(load),
		.chain_clear_n_in(clear_n), .relay_drive_out(drive), .chain_data_out(tail));
	rlc_listener_model rlc_listener_model_i (.mclk_in(mclk_in), .data_out(data),
		.shift_out(shift), .load_out(load), .clear_n_out(clear_n));

	// Free-running 100 MHz clock.
	initial begin
		mclk_in = 1'h0;
		forever #5 mclk_in = ~mclk_in;
	end

	// A hang is cut short well beyond the few hundred cycles needed.
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic cmp_drv(input logic [71:0] exp, input string what);
		total_checks++;
		if (drive !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t %s: %h not %h", $time, what, drive, exp);
		end
	endtask

	task automatic cmp_tail(input rlc_byte_t exp, input string what);
		total_checks++;
		if (tail !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t %s: %h not %h", $time, what, tail, exp);
		end
	endtask

	// Byte n of a string lands in stage 13-n, two stages to a card.
	function automatic logic [71:0] bank(input logic [71:0] s);
		logic [71:0] b;
		int st;
		b = 72'h0;
		for (int n = 1; n <= 12; n++) begin
			st = 13 - n;
			b[((st - 1) / 2) * 12 + ((st - 1) % 2) * 6 +: 6] = s[(n - 1) * 6 +: 6];
		end
		return b;
	endfunction

	// Bit six is set so no data byte can pass for the terminator.
	task automatic send_string(input logic [71:0] s, input logic [71:0] old);
		for (int n = 1; n <= 12; n++) begin
			rlc_listener_model_i.send_char({1'h1, s[(n - 1) * 6 +: 6]});
			if (n == 11) cmp_tail(6'h00, "tail after eleven");
		end
		cmp_tail(s[5:0], "first byte at tail");
		cmp_drv(old, "latches before load");
		rlc_listener_model_i.send_char(7'h0D);
		cmp_drv(bank(s), "latches after load");
	endtask

	task automatic t_reset_state();
		cmp_drv(72'h0, "drive after reset");
		cmp_tail(6'h00, "tail after reset");
	endtask

	// Distinct bytes, then one extra shift that must leave the latches alone.
	task automatic t_pattern();
		logic [71:0] s;
		for (int n = 0; n < 12; n++) s[n * 6 +: 6] = 6'((n * 11) ^ 21);
		send_string(s, 72'h0);
		rlc_listener_model_i.send_char(7'h6A);
		cmp_tail(s[11:6], "second byte at tail");
		cmp_drv(bank(s), "latches stand");
	endtask

	// Clear wipes stages and latches and blocks a shift while low.
	task automatic t_clear();
		rlc_listener_model_i.set_clear(1'h0);
		cmp_drv(72'h0, "drive in clear");
		cmp_tail(6'h00, "tail in clear");
		rlc_listener_model_i.send_char(7'h7F);
		cmp_tail(6'h00, "shift in clear");
		rlc_listener_model_i.set_clear(1'h1);
		rlc_listener_model_i.send_char(7'h0D);
		cmp_drv(72'h0, "load after clear");
	endtask

	// Reset in mid-run wipes stages and latches, and the chain then works again.
	task automatic t_mid_reset();
		arst_n_in = 1'h0;
		repeat (2) @(negedge mclk_in);
		cmp_drv(72'h0, "drive in reset");
		cmp_tail(6'h00, "tail in reset");
		arst_n_in = 1'h1;
		@(negedge mclk_in);
		cmp_drv(72'h0, "drive after reset release");
		send_string(72'h0123456789ABCDEF01, 72'h0);
	endtask

	task automatic t_all_on();
		send_string({12{6'h3F}}, 72'h0);
	endtask

	// Reset for 16 cycles, then the scenarios in turn.
	initial begin
		arst_n_in = 1'h0;
		repeat (16) @(negedge mclk_in);
		arst_n_in = 1'h1;
		@(negedge mclk_in);
		t_reset_state();
		t_pattern();
		t_mid_reset();
		t_clear();
		t_all_on();
		summarize();
	end
endmodule

// File: testbench/rlc_listener_model.sv
// Purpose: Behavioural bus listener that drives data, shift, load and clear pins.
// Assumes: Tasks are entered just after a falling edge of mclk_in.
// Notes: Data pins are inverted once a pulse ends, so stale data never looks valid.
`timescale 1ns/1ps

module rlc_listener_model (
	input wire logic mclk_in,
	output rlc_pkg::rlc_byte_t data_out,
	output logic shift_out,
	output logic load_out,
	output logic clear_n_out
);
	import rlc_pkg::*;

	// Pins start idle with clear released.
	initial begin
		data_out = 6'h2A;
		shift_out = 1'h0;
		load_out = 1'h0;
		clear_n_out = 1'h1;
	end

	// Waits n clocks; every pin change lands on a falling edge.
	task automatic hold(input int n);
		repeat (n) @(negedge mclk_in);
	endtask

	// One received character in nine clocks: the terminator steers the pulse to load.
	task automatic send_char(input logic [6:0] c);
		data_out = c[5:0];
		hold(3);
		if (c == 7'h0D) begin
			load_out = 1'h1;
		end else begin
			shift_out = 1'h1;
		end
		hold(3);
		load_out = 1'h0;
		shift_out = 1'h0;
		hold(1);
		data_out = ~c[5:0];
		hold(2);
	endtask

	// Clear follows a device clear command as a plain level.
	task automatic set_clear(input logic lvl);
		clear_n_out = lvl;
		hold(4);
	endtask
endmodule
